/* hdl/vac_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; both sides share the clock enable.
`timescale 1ns/1ps
`default_nettype none
module vac_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } vac_fifo_state_type;
  vac_fifo_state_type st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign out_valid_out = st.wr != st.rd;
  assign in_ready_out = (st.wr - st.rd) != (AW+1)'(DEPTH);
  assign out_data_out = mem[st.rd[AW-1:0]];
  assign push = enable_in && in_valid_in && in_ready_out;
  assign pop = enable_in && out_valid_out && out_ready_in;
  always_comb begin
    next_st = st;
    if (push) next_st.wr = st.wr + 1'b1;
    if (pop) next_st.rd = st.rd + 1'b1;
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge clock_in) begin
    if (push) mem[st.wr[AW-1:0]] <= in_data_in;
  end
endmodule
`default_nettype wire

/* hdl/vac_pkg.sv */
// Constants for the video area-of-interest control register block.
// Assumes a synchronous peripheral-bus window with word offsets.
package vac_pkg;
  localparam int VAC_PIX_W = 16;
  localparam int VAC_DIM_W = 12;
  localparam logic [7:0] VAC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] VAC_OFF_COLUMNS = 8'h04;
  localparam logic [7:0] VAC_OFF_ROWS = 8'h08;
  localparam logic [7:0] VAC_OFF_START_COL = 8'h0c;
  localparam logic [7:0] VAC_OFF_START_ROW = 8'h10;
  localparam logic [7:0] VAC_OFF_PADDING = 8'h14;
  localparam logic [7:0] VAC_OFF_PIXFMT = 8'h18;
  localparam logic [7:0] VAC_OFF_COL_LIMIT = 8'h1c;
  localparam logic [7:0] VAC_OFF_ROW_LIMIT = 8'h20;
  localparam logic [7:0] VAC_OFF_BYTE_TOTAL = 8'h24;
  localparam logic [7:0] VAC_OFF_MODE = 8'h28;
  localparam logic [7:0] VAC_OFF_GAIN = 8'h2c;
  localparam logic [7:0] VAC_OFF_PKT_FLOOR = 8'h30;
  localparam logic [7:0] VAC_OFF_PKT_CEIL = 8'h34;
  localparam logic [7:0] VAC_OFF_PKT_STEP = 8'h38;
  localparam int VAC_ACQ_BIT = 0;
  localparam int VAC_LINE_PAD_LSB = 16;
  localparam int VAC_PAD_W = 16;
  localparam logic [31:0] VAC_MODE_CONTINUOUS = 32'h0000_0001;
  localparam logic [31:0] VAC_PAD_RESET = 32'h0000_0000;
  localparam logic [11:0] VAC_COLUMNS_RESET = 12'h500;
  localparam logic [11:0] VAC_ROWS_RESET = 12'h3c0;
  localparam logic [31:0] VAC_PIXFMT_MONO16 = 32'h0110_0007;
  localparam logic [31:0] VAC_PIXFMT_MONO8 = 32'h0108_0001;
  localparam logic [31:0] VAC_COL_LIMIT = 32'h0000_0500;
  localparam logic [31:0] VAC_ROW_LIMIT = 32'h0000_03c0;
  localparam logic [31:0] VAC_PKT_FLOOR = 32'h0000_0240;
  localparam logic [31:0] VAC_PKT_CEIL = 32'h0000_2328;
  localparam logic [31:0] VAC_PKT_STEP = 32'h0000_0004;
  localparam int VAC_FIFO_DEPTH = 16;
endpackage

/* hdl/vac_video_regs.sv */
// Video control registers, area-of-interest crop and pixel stage.
// Assumes a synchronous peripheral-bus window and an asynchronous sensor.
// What this block does
// - Takes sensor frame, data valid, 16-bit pixel
// - Drives processor frame, line valid, pixel
// - Frame columns, 12 bits, 1 to limit; not checked, any 12-bit value is stored
// - Frame rows, 12 bits, 1 to limit; not checked, any 12-bit value is stored
// - Control bit 0 starts/stops, resets zero
// - Line padding bits 31..16, reset zero
// - Frame padding bits 15..0, reset zero
// - Padding CPU writable, feeds leader packet
// - Only continuous mode, value one
// - Read-only pixel format code
// - Read-only frame byte total
// - Read-only sensor column, row limits
// - Read-only packet size floor, ceiling, step
// - Pixels outside window are masked
// - Optional reduction from twelve to eight bits
`timescale 1ns/1ps
`default_nettype none
module vac_video_regs
  import vac_pkg::*;
#(
  parameter int PIX_W = VAC_PIX_W,
  parameter int FIFO_DEPTH = VAC_FIFO_DEPTH,
  parameter bit REDUCE_TO_8 = 1'b0
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic bus_select_in,
  input wire logic bus_write_in,
  input wire logic [7:0] bus_address_in,
  input wire logic [31:0] bus_write_data_in,
  output logic [31:0] bus_read_data_out,
  output logic bus_ready_out,
  input wire logic sensor_frame_valid_in,
  input wire logic sensor_pixel_valid_in,
  input wire logic [PIX_W-1:0] sensor_pixel_word_in,
  output logic proc_frame_valid_out,
  output logic proc_line_valid_out,
  output logic [PIX_W-1:0] proc_pixel_word_out,
  input wire logic proc_ready_in,
  output logic sensor_ready_out,
  output logic acquisition_out,
  output logic [7:0] sensor_gain_out,
  output logic [31:0] stream_padding_counts_out
);
  initial begin
    if (PIX_W != VAC_PIX_W) $error("PIX_W must be 16");
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  typedef struct packed {
    logic acq;
    logic [VAC_DIM_W-1:0] cols;
    logic [VAC_DIM_W-1:0] rows;
    logic [VAC_DIM_W-1:0] start_col;
    logic [VAC_DIM_W-1:0] start_row;
    logic [31:0] padding;
    logic [31:0] mode;
    logic [7:0] gain;
    logic [VAC_DIM_W-1:0] act_cols;
    logic [VAC_DIM_W-1:0] act_rows;
    logic [VAC_DIM_W-1:0] act_col0;
    logic [VAC_DIM_W-1:0] act_row0;
    logic frame_on;
    logic [VAC_DIM_W-1:0] col;
    logic [VAC_DIM_W-1:0] row;
    logic line_seen;
    logic [31:0] byte_count;
    logic [31:0] byte_total;
    logic [31:0] rdata;
    logic ack;
    logic fv_s1, fv_s2, fv_s3;
    logic dv_s1, dv_s2;
    logic [PIX_W-1:0] px_s1, px_s2;
  } vac_state_type;
  vac_state_type st, next_st;

  function automatic logic in_span(input logic [VAC_DIM_W-1:0] pos, input logic [VAC_DIM_W-1:0] first,
                                   input logic [VAC_DIM_W-1:0] count);
    logic [VAC_DIM_W:0] stop;
    stop = {1'b0, first} + {1'b0, count};
    in_span = ({1'b0, pos} >= {1'b0, first}) && ({1'b0, pos} < stop);
  endfunction

  logic [PIX_W-1:0] shaped;
  logic keep, fifo_in_ready, fifo_out_valid, bus_wr, frame_rise, frame_fall, line_end;
  logic [PIX_W+1:0] fifo_out;

  assign shaped = REDUCE_TO_8 ? {8'h00, st.px_s2[11:4]} : st.px_s2;
  assign keep = st.acq && st.frame_on && st.dv_s2 && in_span(st.col, st.act_col0, st.act_cols)
                && in_span(st.row, st.act_row0, st.act_rows);
  assign frame_rise = st.fv_s2 && !st.fv_s3;
  assign frame_fall = !st.fv_s2 && st.fv_s3;
  assign line_end = st.line_seen && !st.dv_s2;
  assign bus_wr = enable_in && bus_select_in && bus_write_in && !st.ack;

  always_comb begin
    next_st = st;
    next_st.fv_s1 = sensor_frame_valid_in;
    next_st.fv_s2 = st.fv_s1;
    next_st.fv_s3 = st.fv_s2;
    next_st.dv_s1 = sensor_pixel_valid_in;
    next_st.dv_s2 = st.dv_s1;
    next_st.px_s1 = sensor_pixel_word_in;
    next_st.px_s2 = st.px_s1;
    next_st.ack = bus_select_in && !st.ack;
    if (bus_wr) begin
      unique case (bus_address_in)
        VAC_OFF_CONTROL: next_st.acq = bus_write_data_in[VAC_ACQ_BIT];
        VAC_OFF_COLUMNS: next_st.cols = bus_write_data_in[VAC_DIM_W-1:0];
        VAC_OFF_ROWS: next_st.rows = bus_write_data_in[VAC_DIM_W-1:0];
        VAC_OFF_START_COL: next_st.start_col = bus_write_data_in[VAC_DIM_W-1:0];
        VAC_OFF_START_ROW: next_st.start_row = bus_write_data_in[VAC_DIM_W-1:0];
        VAC_OFF_PADDING: next_st.padding = bus_write_data_in;
        VAC_OFF_MODE: next_st.mode = VAC_MODE_CONTINUOUS;
        VAC_OFF_GAIN: next_st.gain = bus_write_data_in[7:0];
        default: next_st.acq = st.acq;
      endcase
    end
    next_st.rdata = '0;
    unique case (bus_address_in)
      VAC_OFF_CONTROL: next_st.rdata[VAC_ACQ_BIT] = st.acq;
      VAC_OFF_COLUMNS: next_st.rdata[VAC_DIM_W-1:0] = st.cols;
      VAC_OFF_ROWS: next_st.rdata[VAC_DIM_W-1:0] = st.rows;
      VAC_OFF_START_COL: next_st.rdata[VAC_DIM_W-1:0] = st.start_col;
      VAC_OFF_START_ROW: next_st.rdata[VAC_DIM_W-1:0] = st.start_row;
      VAC_OFF_PADDING: next_st.rdata = st.padding;
      VAC_OFF_PIXFMT: next_st.rdata = REDUCE_TO_8 ? VAC_PIXFMT_MONO8 : VAC_PIXFMT_MONO16;
      VAC_OFF_COL_LIMIT: next_st.rdata = VAC_COL_LIMIT;
      VAC_OFF_ROW_LIMIT: next_st.rdata = VAC_ROW_LIMIT;
      VAC_OFF_BYTE_TOTAL: next_st.rdata = st.byte_total;
      VAC_OFF_MODE: next_st.rdata = st.mode;
      VAC_OFF_GAIN: next_st.rdata[7:0] = st.gain;
      VAC_OFF_PKT_FLOOR: next_st.rdata = VAC_PKT_FLOOR;
      VAC_OFF_PKT_CEIL: next_st.rdata = VAC_PKT_CEIL;
      VAC_OFF_PKT_STEP: next_st.rdata = VAC_PKT_STEP;
      default: next_st.rdata = '0;
    endcase
    if (frame_rise) begin
      next_st.act_cols = st.cols;
      next_st.act_rows = st.rows;
      next_st.act_col0 = st.start_col;
      next_st.act_row0 = st.start_row;
      next_st.frame_on = 1'b1;
      next_st.col = '0;
      next_st.row = '0;
      next_st.line_seen = 1'b0;
      next_st.byte_count = '0;
    end else if (frame_fall) begin
      next_st.frame_on = 1'b0;
      if (st.frame_on) next_st.byte_total = st.byte_count;
    end else if (st.frame_on) begin
      if (st.dv_s2) begin
        next_st.col = st.col + 1'b1;
        next_st.line_seen = 1'b1;
      end else if (line_end) begin
        next_st.col = '0;
        next_st.row = st.row + 1'b1;
        next_st.line_seen = 1'b0;
      end
      if (keep && fifo_in_ready) next_st.byte_count = st.byte_count + (REDUCE_TO_8 ? 32'h1 : 32'h2);
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
      st.cols <= VAC_COLUMNS_RESET;
      st.rows <= VAC_ROWS_RESET;
      st.padding <= VAC_PAD_RESET;
      st.mode <= VAC_MODE_CONTINUOUS;
    end else if (enable_in) begin
      st <= next_st;
    end
  end

  // stream through the FIFO; a full FIFO drops pixels.
  vac_fifo #(.WIDTH(PIX_W + 2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .enable_in(enable_in),
    .in_valid_in(keep || frame_rise || frame_fall),
    .in_ready_out(fifo_in_ready),
    .in_data_in({st.fv_s2, keep, shaped}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(proc_ready_in),
    .out_data_out(fifo_out)
  );

  assign proc_frame_valid_out = fifo_out_valid && fifo_out[PIX_W+1];
  assign proc_line_valid_out = fifo_out_valid && fifo_out[PIX_W];
  assign proc_pixel_word_out = fifo_out[PIX_W-1:0];
  assign sensor_ready_out = fifo_in_ready;
  assign bus_read_data_out = st.rdata;
  assign bus_ready_out = st.ack;
  assign acquisition_out = st.acq;
  assign sensor_gain_out = st.gain;
  assign stream_padding_counts_out = st.padding;

  a_ctrl_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
    bus_wr && bus_address_in == VAC_OFF_CONTROL |=> acquisition_out == $past(bus_write_data_in[VAC_ACQ_BIT]))
    else $error("control bit not written");
  a_mode_fixed: assert property (@(posedge clock_in) disable iff (!resetn_in)
    st.mode == VAC_MODE_CONTINUOUS) else $error("mode not continuous");
  a_pad_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
    bus_wr && bus_address_in == VAC_OFF_PADDING |=> stream_padding_counts_out == $past(bus_write_data_in))
    else $error("padding not written");
  a_geom_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
    enable_in && !frame_rise |=> $stable(st.act_cols) && $stable(st.act_col0)) else $error("geometry moved");
  a_mask_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
    !st.acq |-> !keep) else $error("pixel kept while stopped");
  a_limit_read: assert property (@(posedge clock_in) disable iff (!resetn_in)
    enable_in && bus_address_in == VAC_OFF_COL_LIMIT |=> bus_read_data_out == VAC_COL_LIMIT)
    else $error("column limit wrong");
  a_pkt_read: assert property (@(posedge clock_in) disable iff (!resetn_in)
    enable_in && bus_address_in == VAC_OFF_PKT_STEP |=> bus_read_data_out == VAC_PKT_STEP)
    else $error("packet step wrong");
  a_line_in_frame: assert property (@(posedge clock_in) disable iff (!resetn_in)
    proc_line_valid_out |-> proc_frame_valid_out) else $error("line valid outside frame");
  a_ack_pulse: assert property (@(posedge clock_in) disable iff (!resetn_in)
    bus_ready_out |=> !bus_ready_out || !enable_in) else $error("ack held");
  c_frame: cover property (@(posedge clock_in) disable iff (!resetn_in) frame_rise ##[1:200] frame_fall);
  c_pixel_out: cover property (@(posedge clock_in) disable iff (!resetn_in) proc_line_valid_out && proc_ready_in);
  c_full: cover property (@(posedge clock_in) disable iff (!resetn_in) !fifo_in_ready);
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Bench for the video register block: bus accesses, crop and FIFO stall.
// Assumes the sensor model beside it and the design's package.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vac_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic proc_ready = 1'b1;
  logic start = 1'b0;
  logic saw_full = 1'b0;
  logic [7:0] scols = 8'h00;
  logic [7:0] srows = 8'h00;
  logic [31:0] rdata, pad, q;
  logic ready, fv, pv, prf, plv, sready, acq;
  logic [15:0] pw, ppw;
  logic [7:0] gain, frames;
  logic [15:0] pix_q[$];
  int bad_count = 0;
  int n_tests = 0;
  int i;
  always #5 clock_in = ~clock_in;
  vac_video_regs vac_video_regs_i (.clock_in(clock_in), .resetn_in(resetn_in), .enable_in(1'b1),
    .bus_select_in(sel), .bus_write_in(wr), .bus_address_in(addr), .bus_write_data_in(wdata),
    .bus_read_data_out(rdata), .bus_ready_out(ready), .sensor_frame_valid_in(fv),
    .sensor_pixel_valid_in(pv), .sensor_pixel_word_in(pw), .proc_frame_valid_out(prf),
    .proc_line_valid_out(plv), .proc_pixel_word_out(ppw), .proc_ready_in(proc_ready),
    .sensor_ready_out(sready), .acquisition_out(acq), .sensor_gain_out(gain),
    .stream_padding_counts_out(pad));
  vac_sensor_model vac_sensor_model_i (.clock_in(clock_in), .start_in(start), .cols_in(scols),
    .rows_in(srows), .frame_valid_out(fv), .pixel_valid_out(pv), .pixel_word_out(pw), .frames_out(frames));
  always @(posedge clock_in) begin
    if (plv === 1'b1 && proc_ready === 1'b1) begin
      pix_q.push_back(ppw);
    end
    if (sready === 1'b0) begin
      saw_full <= 1'b1;
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request is held until ready is sampled high, then released at that edge.
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clock_in);
      if (ready === 1'b1) break;
    end
    r = rdata;
    sel <= 1'b0;
    if (k == 20) begin
      bad_count++;
      close_out();
    end
    @(posedge clock_in);
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d, q);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask
  task automatic frame(input logic [7:0] c, input logic [7:0] r);
    logic [7:0] f0;
    int k;
    f0 = frames;
    scols <= c;
    srows <= r;
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    for (k = 0; k < 2000 && frames === f0; k++) @(posedge clock_in);
    if (k == 2000) begin
      bad_count++;
      close_out();
    end
    repeat (20) @(posedge clock_in);
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    rd("control", VAC_OFF_CONTROL, 32'h0);
    rd("padding", VAC_OFF_PADDING, VAC_PAD_RESET);
    rd("mode", VAC_OFF_MODE, VAC_MODE_CONTINUOUS);
    rd("pixfmt", VAC_OFF_PIXFMT, VAC_PIXFMT_MONO16);
    rd("col_limit", VAC_OFF_COL_LIMIT, VAC_COL_LIMIT);
    rd("row_limit", VAC_OFF_ROW_LIMIT, VAC_ROW_LIMIT);
    rd("pkt_floor", VAC_OFF_PKT_FLOOR, VAC_PKT_FLOOR);
    rd("pkt_ceil", VAC_OFF_PKT_CEIL, VAC_PKT_CEIL);
    rd("pkt_step", VAC_OFF_PKT_STEP, VAC_PKT_STEP);
    rd("columns", VAC_OFF_COLUMNS, {20'h0, VAC_COLUMNS_RESET});
    rd("rows", VAC_OFF_ROWS, {20'h0, VAC_ROWS_RESET});
    rd("unmapped", 8'hfc, 32'h0);
    // registers sit on consecutive 4-byte words
    rd("gain_word", VAC_OFF_MODE + 8'h04, 32'h0);
    wrt(VAC_OFF_PIXFMT, 32'h0);
    rd("pixfmt_ro", VAC_OFF_PIXFMT, VAC_PIXFMT_MONO16);
    wrt(VAC_OFF_MODE, 32'h5);
    rd("mode_fixed", VAC_OFF_MODE, VAC_MODE_CONTINUOUS);
    wrt(VAC_OFF_PADDING, 32'h0000_0040);
    rd("padding_rw", VAC_OFF_PADDING, 32'h0000_0040);
    check("padding_out", pad, 32'h0000_0040);
    wrt(VAC_OFF_GAIN, 32'ha5);
    rd("gain", VAC_OFF_GAIN, 32'ha5);
    check("gain_out", {24'h0, gain}, 32'ha5);
    wrt(VAC_OFF_COLUMNS, 32'h4);
    wrt(VAC_OFF_ROWS, 32'h2);
    wrt(VAC_OFF_START_COL, 32'h1);
    wrt(VAC_OFF_START_ROW, 32'h1);
    rd("columns_rw", VAC_OFF_COLUMNS, 32'h4);
    rd("rows_rw", VAC_OFF_ROWS, 32'h2);
    wrt(VAC_OFF_CONTROL, 32'hffff_ffff);
    rd("control_bits", VAC_OFF_CONTROL, 32'h1);
    check("acq_on", {31'h0, acq}, 32'h1);
    frame(8'h06, 8'h03);
    check("kept", pix_q.size(), 32'h8);
    check("first_pix", {16'h0, pix_q[0]}, 32'h0101);
    check("last_pix", {16'h0, pix_q[7]}, 32'h0204);
    rd("byte_total", VAC_OFF_BYTE_TOTAL, 32'h10);
    wrt(VAC_OFF_COLUMNS, 32'h8);
    wrt(VAC_OFF_ROWS, 32'h4);
    wrt(VAC_OFF_START_COL, 32'h0);
    wrt(VAC_OFF_START_ROW, 32'h0);
    pix_q.delete();
    proc_ready <= 1'b0;
    frame(8'h08, 8'h04);
    check("fifo_full", {31'h0, saw_full}, 32'h1);
    proc_ready <= 1'b1;
    // The head may be a frame marker with line valid low, so wait for both valids to drop.
    for (i = 0; i < 100 && (plv !== 1'b0 || prf !== 1'b0); i++) @(posedge clock_in);
    if (i == 100) begin
      bad_count++;
      close_out();
    end
    repeat (5) @(posedge clock_in);
    check("drained", {31'h0, plv}, 32'h0);
    check("bounded", {31'h0, pix_q.size() <= 16 && pix_q.size() > 0}, 32'h1);
    wrt(VAC_OFF_CONTROL, 32'h0);
    check("acq_off", {31'h0, acq}, 32'h0);
    pix_q.delete();
    frame(8'h08, 8'h04);
    check("stopped", pix_q.size(), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire

/* testbench/vac_sensor_model.sv */
// Sensor model: sends one frame of counted pixels on each start pulse.
// Assumes the bench's clock; pixel words are {row, column} of the sensor.
`timescale 1ns/1ps
`default_nettype none
module vac_sensor_model (
  input wire logic clock_in,
  input wire logic start_in,
  input wire logic [7:0] cols_in,
  input wire logic [7:0] rows_in,
  output logic frame_valid_out,
  output logic pixel_valid_out,
  output logic [15:0] pixel_word_out,
  output logic [7:0] frames_out
);
  int r;
  int c;
  initial begin
    frame_valid_out = 1'b0;
    pixel_valid_out = 1'b0;
    pixel_word_out = 16'hffff;
    frames_out = 8'h00;
    forever begin
      @(posedge clock_in);
      if (start_in === 1'b1) begin
        frame_valid_out <= 1'b1;
        repeat (4) @(posedge clock_in);
        for (r = 0; r < rows_in; r++) begin
          for (c = 0; c < cols_in; c++) begin
            pixel_valid_out <= 1'b1;
            pixel_word_out <= {r[7:0], c[7:0]};
            @(posedge clock_in);
          end
          pixel_valid_out <= 1'b0;
          // Idle data is inverted so the design cannot lean on a held word.
          pixel_word_out <= ~pixel_word_out;
          repeat (6) @(posedge clock_in);
        end
        frame_valid_out <= 1'b0;
        repeat (6) @(posedge clock_in);
        frames_out <= frames_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
